// ### fss_pkg.sv
// Package of constants, states and carriers for the flyback startup/standby sequencer
// Operation
// - At minimum peak threshold enter standby burst and keep high-side command off.
// - Standby burst uses two pulses, minimum threshold, regulates only by off-time.
// - Lockout charging closes both path switches with high charge-limit resistance below 1 V.
// - Above low detection level select the small charge-limit resistance.
// - At turn-on level open both path switches and start charging the reference.
// - After reference settles close the bias regulator switch to the gate-bias pin.
// - Gate-bias settling faster than expected flags open-pin fault and halts.
// - Gate-bias settled without fault asserts run and enters wake state.
// - After run asserts wait a fixed delay before the first low-side pulse.
// - Soft-start clamps level one, blocks high side while aux low, five pulses.
// - Aux above level one and five pulses done raises threshold to level two.
// - Level one lasting past timeout forces level two.
// - Aux above level two allows maximum threshold.
// - Gate-bias pin above its over-voltage threshold raises a protection event.
// - Survival regulator enabled only while feedback demands switching stop.
// - In survival, pulse without limit while supply below threshold, stop above.
// - Feedback release leaves survival and returns control to normal mode.
`default_nettype none
package fss_pkg;
  localparam int unsigned CLK_MHZ           = 125;
  localparam int unsigned RUN_DELAY_NS      = 2200;
  localparam int unsigned RUN_DELAY_CYC     = RUN_DELAY_NS * CLK_MHZ / 1000;
  localparam int unsigned OPEN_MIN_NS       = 25000;
  localparam int unsigned OPEN_MIN_CYC      = (OPEN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SS_TIMEOUT_US     = 1000;
  localparam int unsigned SS_TIMEOUT_CYC    = SS_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned SS_PULSES         = 5;
  localparam int unsigned BURST_PULSES      = 2;
  localparam logic [17:0] CNT_RESET         = 18'h0_0000;

  typedef enum logic [1:0] {
    FSS_LVL_MIN,
    FSS_LVL_ONE,
    FSS_LVL_TWO,
    FSS_LVL_MAX
  } fss_lvl_e;

  typedef enum logic [2:0] {
    FSS_LOCKOUT,
    FSS_REF_CHARGE,
    FSS_BIAS_SETTLE,
    FSS_OPEN_FAULT,
    FSS_WAKE,
    FSS_RUN
  } fss_state_e;

  typedef struct packed {
    logic supply_above_1v;
    logic supply_above_on;
    logic supply_below_off;
    logic supply_below_surv;
    logic ref_settled;
    logic bias_settled;
    logic bias_over_volt;
    logic aux_above_one;
    logic aux_above_two;
    logic thr_at_min;
    logic fb_stop;
  } fss_sense_s;

  typedef struct packed {
    logic     charge_path_switch;
    logic     charge_res_high;
    logic     gate_path_switch;
    logic     bias_regulator_switch;
    logic     ref_enable;
    logic     run;
    logic     open_pin_fault;
    logic     bias_ov_event;
    logic     standby_burst_state;
    logic     survival_active;
    logic     hs_enable;
    logic     ls_enable;
    logic     burst_limit;
    fss_lvl_e peak_current_threshold;
  } fss_ctrl_s;
endpackage
`default_nettype wire

// ### fss_sequencer.sv
// Startup, standby burst and survival sequencer of the flyback controller
`default_nettype none
module fss_sequencer
  import fss_pkg::*;
#(
  parameter int unsigned SS_TIMEOUT = SS_TIMEOUT_CYC
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire fss_sense_s sense,
  input  wire logic       low_side_pulse_done,
  output logic [7:0]      burst_pulse_count,
  output fss_ctrl_s       ctrl
);
  typedef struct packed {
    fss_state_e  st;
    logic [17:0] cnt;
    logic [2:0]  ss_pulses;
    logic [7:0]  bpc;
    fss_ctrl_s   c;
  } fss_regs_s;

  fss_regs_s r;
  fss_regs_s next_r;

  always_comb begin
    next_r = r;
    next_r.c.bias_ov_event = sense.bias_over_volt;
    unique case (r.st)
      // ==========================================================
      // Lockout charging
      FSS_LOCKOUT: begin
        next_r.c.run                   = 1'b0;
        next_r.c.charge_path_switch    = 1'b1;
        next_r.c.gate_path_switch      = 1'b1;
        next_r.c.charge_res_high       = !sense.supply_above_1v;
        next_r.c.bias_regulator_switch = 1'b0;
        next_r.c.ref_enable            = 1'b0;
        next_r.c.hs_enable             = 1'b0;
        next_r.c.ls_enable             = 1'b0;
        if (sense.supply_above_on) begin
          next_r.c.charge_path_switch = 1'b0;
          next_r.c.gate_path_switch   = 1'b0;
          next_r.c.ref_enable         = 1'b1;
          next_r.st                   = FSS_REF_CHARGE;
        end
      end
      FSS_REF_CHARGE: begin
        if (sense.ref_settled) begin
          next_r.c.bias_regulator_switch = 1'b1;
          next_r.cnt                     = CNT_RESET;
          next_r.st                      = FSS_BIAS_SETTLE;
        end
      end
      // ==========================================================
      // Gate-bias settle and open-pin check
      FSS_BIAS_SETTLE: begin
        next_r.cnt = r.cnt + 18'h0_0001;
        if (sense.bias_settled) begin
          if (r.cnt < 18'(OPEN_MIN_CYC)) begin
            next_r.c.open_pin_fault = 1'b1;
            next_r.st               = FSS_OPEN_FAULT;
          end else begin
            next_r.c.run = 1'b1;
            next_r.cnt   = CNT_RESET;
            next_r.st    = FSS_WAKE;
          end
        end
      end
      FSS_OPEN_FAULT: begin
        next_r.c.run = 1'b0;
      end
      FSS_WAKE: begin
        next_r.cnt = r.cnt + 18'h0_0001;
        if (r.cnt >= 18'(RUN_DELAY_CYC - 1)) begin
          next_r.c.ls_enable              = 1'b1;
          next_r.c.peak_current_threshold = FSS_LVL_ONE;
          next_r.ss_pulses                = 3'h0;
          next_r.cnt                      = CNT_RESET;
          next_r.st                       = FSS_RUN;
        end
      end
      // ==========================================================
      // Run: soft-start, standby burst, survival
      FSS_RUN: begin
        if (r.c.peak_current_threshold == FSS_LVL_ONE) begin
          next_r.cnt = r.cnt + 18'h0_0001;
          if (low_side_pulse_done && r.ss_pulses < 3'(SS_PULSES))
            next_r.ss_pulses = r.ss_pulses + 3'h1;
          if ((sense.aux_above_one && r.ss_pulses >= 3'(SS_PULSES)) ||
              r.cnt >= 18'(SS_TIMEOUT - 1))
            next_r.c.peak_current_threshold = FSS_LVL_TWO;
        end else if (r.c.peak_current_threshold == FSS_LVL_TWO && sense.aux_above_two) begin
          next_r.c.peak_current_threshold = FSS_LVL_MAX;
        end else if (r.c.peak_current_threshold == FSS_LVL_MAX && sense.thr_at_min) begin
          next_r.c.peak_current_threshold = FSS_LVL_MIN;
        end else if (r.c.peak_current_threshold == FSS_LVL_MIN && !sense.thr_at_min) begin
          next_r.c.peak_current_threshold = FSS_LVL_MAX;
        end
        next_r.c.standby_burst_state = (next_r.c.peak_current_threshold == FSS_LVL_MIN);
        next_r.c.survival_active     = sense.fb_stop;
        if (sense.fb_stop) begin
          next_r.c.hs_enable   = 1'b0;
          next_r.c.ls_enable   = sense.supply_below_surv;
          next_r.c.burst_limit = 1'b0;
        end else begin
          next_r.c.ls_enable   = 1'b1;
          next_r.c.burst_limit = next_r.c.standby_burst_state;
          next_r.c.hs_enable   = !next_r.c.standby_burst_state &&
                                 !(next_r.c.peak_current_threshold == FSS_LVL_ONE && !sense.aux_above_one);
        end
        if (next_r.c.burst_limit) begin
          if (low_side_pulse_done)
            next_r.bpc = (r.bpc >= 8'(BURST_PULSES - 1)) ? 8'h00 : r.bpc + 8'h01;
        end else begin
          next_r.bpc = 8'h00;
        end
      end
      default: next_r.st = FSS_LOCKOUT;
    endcase
    if (sense.supply_below_off && r.st != FSS_LOCKOUT) begin
      next_r.st                       = FSS_LOCKOUT;
      next_r.c.run                    = 1'b0;
      next_r.c.ls_enable              = 1'b0;
      next_r.c.hs_enable              = 1'b0;
      next_r.c.survival_active        = 1'b0;
      next_r.c.standby_burst_state    = 1'b0;
      next_r.c.open_pin_fault         = 1'b0;
      next_r.c.peak_current_threshold = FSS_LVL_MIN;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ctrl              = r.c;
  assign burst_pulse_count = r.bpc;
endmodule
`default_nettype wire

// ### fss_properties.sv
// Assertion checker for the startup and standby sequencer
`default_nettype none
module fss_checker import fss_pkg::*; #(
  parameter int unsigned SS_TIMEOUT = 200
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire fss_sense_s sense,
  input wire fss_ctrl_s  ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Cycle counters
  int unsigned run_cnt;
  int unsigned one_cnt;
  always_ff @(posedge clk) begin
    run_cnt <= (srst || !ctrl.run) ? 0 : run_cnt + 1;
    one_cnt <= (srst || ctrl.peak_current_threshold != FSS_LVL_ONE) ? 0 : one_cnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_ov; sense.bias_over_volt |=> ctrl.bias_ov_event; endproperty
  a_ov: assert property (p_ov) else $error("over-voltage event missing");
  property p_sby; ctrl.standby_burst_state |-> !ctrl.hs_enable && ctrl.peak_current_threshold == FSS_LVL_MIN;
  endproperty
  a_sby: assert property (p_sby) else $error("standby with high side or threshold");
  property p_wake; ctrl.run && run_cnt < 274 |-> !ctrl.ls_enable; endproperty
  a_wake: assert property (p_wake) else $error("low side before wake delay");
  property p_one; ctrl.peak_current_threshold == FSS_LVL_ONE && !$past(sense.aux_above_one) |-> !ctrl.hs_enable;
  endproperty
  a_one: assert property (p_one) else $error("high side on at level one");
  property p_tmo; ctrl.peak_current_threshold == FSS_LVL_ONE |-> one_cnt <= SS_TIMEOUT + 2; endproperty
  a_tmo: assert property (p_tmo) else $error("level one past timeout");
  property p_sen; ctrl.survival_active |-> $past(sense.fb_stop); endproperty
  a_sen: assert property (p_sen) else $error("survival without stop request");
  property p_spl; ctrl.survival_active |-> ctrl.ls_enable == $past(sense.supply_below_surv); endproperty
  a_spl: assert property (p_spl) else $error("survival pulsing wrong");
  property p_lko; sense.supply_below_off |=> !ctrl.run; endproperty
  a_lko: assert property (p_lko) else $error("run kept below lockout");
endmodule
bind fss_sequencer fss_checker #(.SS_TIMEOUT(SS_TIMEOUT)) chk (.clk(clk), .srst(srst), .sense(sense), .ctrl(ctrl));
`default_nettype wire

// ### fss_partner.sv
// Gate driver model answering each enabled low-side command with completed pulses
`default_nettype none
module fss_partner #(
  parameter int unsigned GAP = 4
) (
  input  wire logic clk,
  input  wire logic ls_enable,
  output var logic  low_side_pulse_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Pulse generator
  int unsigned cnt = 0;
  always @(posedge clk) begin
    cnt <= ls_enable ? (cnt + 1) % GAP : 0;
    low_side_pulse_done <= ls_enable && cnt == GAP - 1;
  end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the startup and standby sequencer
`default_nettype none
module tb_top import fss_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Stimulus, instances and scenarios
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  fss_sense_s s = '0;
  logic       lsd;
  logic [7:0] bcnt;
  fss_ctrl_s  c;
  int         fail_count = 0;
  int         total_checks = 0;
  always #4 clk = ~clk;
  fss_sequencer #(.SS_TIMEOUT(200)) dut (.clk(clk), .srst(srst), .sense(s), .low_side_pulse_done(lsd),
    .burst_pulse_count(bcnt), .ctrl(c));
  fss_partner pm (.clk(clk), .ls_enable(c.ls_enable), .low_side_pulse_done(lsd));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic to_run;
    step(3200);
    @(posedge clk) s.bias_settled <= 1'b1;
    step(1);
    chk("run", 1, c.run);
    step(280);
    chk("ls_enable", 1, c.ls_enable);
    chk("threshold", FSS_LVL_ONE, c.peak_current_threshold);
    chk("hs_enable", 0, c.hs_enable);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    step(1);
    chk("charge_path", 1, c.charge_path_switch);
    chk("res_high", 1, c.charge_res_high);
    @(posedge clk) s.supply_above_1v <= 1'b1;
    step(1);
    chk("res_high", 0, c.charge_res_high);
    @(posedge clk) s.supply_above_on <= 1'b1;
    step(1);
    chk("gate_path", 0, c.gate_path_switch);
    chk("charge_path", 0, c.charge_path_switch);
    chk("ref_enable", 1, c.ref_enable);
    @(posedge clk) s.ref_settled <= 1'b1;
    step(1);
    chk("bias_switch", 1, c.bias_regulator_switch);
    to_run;
    @(posedge clk) s.aux_above_one <= 1'b1;
    step(30);
    chk("threshold", FSS_LVL_TWO, c.peak_current_threshold);
    @(posedge clk) s.aux_above_two <= 1'b1;
    step(2);
    chk("threshold", FSS_LVL_MAX, c.peak_current_threshold);
    chk("hs_enable", 1, c.hs_enable);
    $display("startup done");
    @(posedge clk) s.thr_at_min <= 1'b1;
    step(20);
    chk("standby", 1, c.standby_burst_state);
    chk("burst_limit", 1, c.burst_limit);
    chk("burst_count_over", 0, 8'(bcnt > 8'h01));
    @(posedge clk) s.thr_at_min <= 1'b0;
    step(2);
    chk("standby", 0, c.standby_burst_state);
    $display("standby done");
    @(posedge clk) begin
      s.fb_stop <= 1'b1;
      s.supply_below_surv <= 1'b1;
      s.bias_over_volt <= 1'b1;
    end
    step(2);
    chk("survival", 1, c.survival_active);
    chk("ls_enable", 1, c.ls_enable);
    chk("ov_event", 1, c.bias_ov_event);
    @(posedge clk) s.supply_below_surv <= 1'b0;
    step(2);
    chk("ls_enable", 0, c.ls_enable);
    @(posedge clk) s.fb_stop <= 1'b0;
    step(2);
    chk("survival", 0, c.survival_active);
    chk("threshold", FSS_LVL_MAX, c.peak_current_threshold);
    $display("survival done");
    @(posedge clk) s.supply_below_off <= 1'b1;
    step(1);
    chk("run", 0, c.run);
    @(posedge clk) s.supply_below_off <= 1'b0;
    step(20);
    chk("open_fault", 1, c.open_pin_fault);
    chk("run", 0, c.run);
    @(posedge clk) s <= '{supply_below_off: 1'b1, supply_above_1v: 1'b1, supply_above_on: 1'b1,
      ref_settled: 1'b1, default: 1'b0};
    step(2);
    chk("open_fault", 0, c.open_pin_fault);
    @(posedge clk) s.supply_below_off <= 1'b0;
    to_run;
    step(210);
    chk("threshold", FSS_LVL_TWO, c.peak_current_threshold);
    $display("fault and timeout done");
    complete_run;
  end
  initial begin
    #100000;
    fail_count++;
    complete_run;
  end
endmodule
`default_nettype wire
